// file: verilog/responder_cfg.svh
// constants for the serial holding register responder
`ifndef RESPONDER_CFG_SVH
`define RESPONDER_CFG_SVH
`define FN_READ 8'h03
`define FN_WRITE 8'h06
`define FN_DIAG 8'h08
`define FN_ERR_FLAG 8'h80
`define SUB_ECHO 16'h0000
`define ADDR_BCAST 8'h00
`define ADDR_MAX 8'hF7
`define READ_MAX 8'h7D
`define QUERY_LEN 8'h08
`define QUERY_MIN 8'h04
`define EXC_FUNC 8'h01
`define EXC_DATA 8'h03
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`endif

// file: verilog/responder_pkg.sv
// types shared by the responder modules
package responder_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_SEND = 3'b010,
    ST_RDREQ = 3'b011,
    ST_RDWAIT = 3'b100
  } state_e;
  typedef enum logic [1:0] {
    K_ECHO = 2'b00,
    K_READ = 2'b01,
    K_ERR = 2'b10
  } kind_e;
  typedef enum logic [1:0] {
    P_BODY = 2'b00,
    P_CRCL = 2'b01,
    P_CRCH = 2'b10,
    P_DONE = 2'b11
  } phase_e;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    state_e st;
    byte_t [7:0] qbuf;
    byte_t len;
    kind_e kind;
    phase_e ph;
    byte_t idx;
    byte_t cnt;
    logic [15:0] raddr;
    logic [15:0] rdat;
    byte_t ecode;
    byte_t txd;
    logic txv;
    logic txlast;
    logic wr;
    logic hi_ok;
  } resp_s;
  typedef struct packed {
    logic [15:0] crc;
  } crc_s;
endpackage : responder_pkg

// file: verilog/crc_if.sv
// carrier between the responder and one check value engine
`timescale 1ns/100ps
interface crc_if;
  logic init;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport ctl (output init, output en, output data, input crc);
  modport eng (input init, input en, input data, output crc);
endinterface : crc_if

// file: verilog/crc16_engine.sv
// byte-wide check value engine, reflected polynomial
`timescale 1ns/100ps
`include "responder_cfg.svh"
module crc16_engine (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // byte feed and result
  crc_if.eng c
);
  import responder_pkg::*;

  crc_s s_r;
  crc_s s_nxt;

  // one byte folded into the running value, lsb first
  function automatic logic [15:0] fold(input logic [15:0] v, input logic [7:0] d);
    logic [15:0] r;
    r = v ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : fold

  // next value: init wins, else fold on enable
  always_comb begin
    s_nxt = s_r;
    if (c.init) begin
      s_nxt.crc = `CRC_INIT;
    end else if (c.en) begin
      s_nxt.crc = fold(s_r.crc, c.data);
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_r.crc <= `CRC_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign c.crc = s_r.crc;
endmodule : crc16_engine

// file: verilog/serial_holding_register_responder.sv
// query interpreter and responder for the serial holding register protocol
// How it works
// [RULE_01] read query: address, 03, start high/low, count high/low, check value
// [RULE_02] address field is register number minus 40001; passed through unchanged
// [RULE_03] a read asks for at most 125 registers
// [RULE_04] read and diagnostic queries to address 0 are invalid
// [RULE_05] read reply: address, 03, byte count, values high first ascending, check
// [RULE_06] byte count equals twice the register count
// [RULE_07] write query: address, 06, register high/low, two data bytes, check value
// [RULE_08] write to address 0 is a broadcast and is performed
// [RULE_09] write and diagnostic replies repeat the query byte for byte
// [RULE_10] nothing is sent for a broadcast query
// [RULE_11] master waits the processing time after a broadcast
// [RULE_12] diagnostic 08 with subfunction 0000 returns the query unchanged
// [RULE_13] diagnostic carries subfunction 0000 then any 16-bit data word
// [RULE_14] own slave addresses are 1 to 247, zero is broadcast
// [RULE_15] error reply carries the function code plus 80
// [RULE_16] check value travels low byte first, then high byte
// [RULE_17] reply starts only after the full query passed its check
`timescale 1ns/100ps
`include "responder_cfg.svh"
module serial_holding_register_responder #(
  parameter logic [7:0] READ_MAX = `READ_MAX
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // own station address, 1 to 247
  input wire responder_pkg::byte_t station_i,
  // received frame bytes
  input wire responder_pkg::byte_t rx_data_i,
  input wire logic rx_valid_i,
  input wire logic rx_end_i,
  // transmit byte stream
  output responder_pkg::byte_t tx_data_o,
  output logic tx_valid_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  // holding register read port, data one cycle after request
  output logic reg_rd_o,
  output logic [15:0] reg_rd_addr_o,
  input wire logic [15:0] reg_rd_data_i,
  // holding register write port
  output logic reg_wr_o,
  output logic [15:0] reg_wr_addr_o,
  output logic [15:0] reg_wr_data_o,
  // busy while a query is being executed or answered
  output logic busy_o
);
  import responder_pkg::*;

  // ------------------------------------------------------------
  // state and check value engines
  // ------------------------------------------------------------
  resp_s s_r;
  resp_s s_nxt;
  logic ld;
  byte_t lb;
  logic feed;
  logic bc;
  logic mine;
  logic good;
  logic [15:0] w1;
  logic [15:0] w2;

  crc_if rxc ();
  crc_if txc ();

  crc16_engine u_rx_crc (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .c(rxc)
  );

  crc16_engine u_tx_crc (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .c(txc)
  );

  // field views of the held query
  assign w1 = {s_r.qbuf[2], s_r.qbuf[3]};
  assign w2 = {s_r.qbuf[4], s_r.qbuf[5]};
  // [RULE_14] station match and broadcast
  assign bc = (s_r.qbuf[0] == `ADDR_BCAST);
  assign mine = (s_r.qbuf[0] == station_i) && (station_i <= `ADDR_MAX) && !bc;
  // [RULE_17] whole frame checks to zero residue
  assign good = (rxc.crc == 16'h0000) && (s_r.len >= `QUERY_MIN) && (bc || mine);

  // receive check runs only while listening
  assign rxc.init = (s_r.st != ST_IDLE);
  assign rxc.en = (s_r.st == ST_IDLE) && rx_valid_i;
  assign rxc.data = rx_data_i;
  // transmit check restarts with each query
  assign txc.init = (s_r.st == ST_EXEC);
  assign txc.en = ld && feed;
  assign txc.data = lb;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    ld = 1'b0;
    lb = 8'h00;
    feed = 1'b0;
    s_nxt.wr = 1'b0;
    unique case (s_r.st)
      ST_IDLE: begin
        // bytes beyond eight are counted and checked but not kept
        if (rx_valid_i) begin
          if (s_r.len < `QUERY_LEN) begin
            s_nxt.qbuf[s_r.len[2:0]] = rx_data_i;
          end
          if (s_r.len != 8'hFF) begin
            s_nxt.len = s_r.len + 8'h01;
          end
        end
        if (rx_end_i) begin
          s_nxt.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        s_nxt.st = ST_IDLE;
        s_nxt.len = 8'h00;
        s_nxt.idx = 8'h00;
        s_nxt.ph = P_BODY;
        s_nxt.hi_ok = 1'b0;
        s_nxt.raddr = w1;
        s_nxt.cnt = s_r.qbuf[5];
        if (good) begin
          // [RULE_01] read query decode
          if (s_r.qbuf[1] == `FN_READ && s_r.len == `QUERY_LEN) begin
            // [RULE_04] broadcast read dropped
            if (!bc) begin
              s_nxt.st = ST_SEND;
              // [RULE_03] count limit
              if (w2 == 16'h0000 || w2 > {8'h00, READ_MAX}) begin
                s_nxt.kind = K_ERR;
                s_nxt.ecode = `EXC_DATA;
              end else begin
                s_nxt.kind = K_READ;
              end
            end
          end else if (s_r.qbuf[1] == `FN_WRITE && s_r.len == `QUERY_LEN) begin
            // [RULE_07] write query decode
            // [RULE_08] write performed, broadcast too
            s_nxt.wr = 1'b1;
            // [RULE_10] silent on broadcast
            if (!bc) begin
              s_nxt.st = ST_SEND;
              s_nxt.kind = K_ECHO;
            end
          end else if (s_r.qbuf[1] == `FN_DIAG && s_r.len == `QUERY_LEN) begin
            // [RULE_04] broadcast diagnostic dropped
            if (!bc) begin
              s_nxt.st = ST_SEND;
              // [RULE_13] only subfunction zero
              if (w1 == `SUB_ECHO) begin
                s_nxt.kind = K_ECHO;
              end else begin
                s_nxt.kind = K_ERR;
                s_nxt.ecode = `EXC_FUNC;
              end
            end
          end else if (!bc) begin
            s_nxt.st = ST_SEND;
            s_nxt.kind = K_ERR;
            s_nxt.ecode = `EXC_FUNC;
          end
        end
      end
      ST_RDREQ: begin
        s_nxt.st = ST_RDWAIT;
      end
      ST_RDWAIT: begin
        s_nxt.rdat = reg_rd_data_i;
        s_nxt.hi_ok = 1'b1;
        s_nxt.st = ST_SEND;
      end
      ST_SEND: begin
        // the output slot frees when empty or taken this cycle
        if (!s_r.txv || tx_ready_i) begin
          s_nxt.txv = 1'b0;
          s_nxt.txlast = 1'b0;
          unique case (s_r.ph)
            P_BODY: begin
              unique case (s_r.kind)
                K_ECHO: begin
                  // [RULE_09] [RULE_12] replay the query unchanged
                  ld = 1'b1;
                  lb = s_r.qbuf[s_r.idx[2:0]];
                  if (s_r.idx == `QUERY_LEN - 8'h01) begin
                    s_nxt.ph = P_DONE;
                    s_nxt.txlast = 1'b1;
                  end
                end
                K_ERR: begin
                  // [RULE_15] flagged function code
                  ld = 1'b1;
                  feed = 1'b1;
                  lb = (s_r.idx == 8'h00) ? s_r.qbuf[0] :
                       (s_r.idx == 8'h01) ? (s_r.qbuf[1] | `FN_ERR_FLAG) : s_r.ecode;
                  if (s_r.idx == 8'h02) begin
                    s_nxt.ph = P_CRCL;
                  end
                end
                default: begin
                  feed = 1'b1;
                  if (s_r.idx < 8'h03) begin
                    // [RULE_05] [RULE_06] header with byte count
                    ld = 1'b1;
                    lb = (s_r.idx == 8'h02) ? {s_r.cnt[6:0], 1'b0} : s_r.qbuf[s_r.idx[2:0]];
                  end else if (!s_r.hi_ok) begin
                    s_nxt.st = ST_RDREQ;
                  end else if (s_r.idx[0]) begin
                    // [RULE_05] high byte first
                    ld = 1'b1;
                    lb = s_r.rdat[15:8];
                  end else begin
                    // [RULE_02] next register ascending
                    ld = 1'b1;
                    lb = s_r.rdat[7:0];
                    s_nxt.hi_ok = 1'b0;
                    s_nxt.raddr = s_r.raddr + 16'h0001;
                    s_nxt.cnt = s_r.cnt - 8'h01;
                    if (s_r.cnt == 8'h01) begin
                      s_nxt.ph = P_CRCL;
                    end
                  end
                end
              endcase
            end
            P_CRCL: begin
              // [RULE_16] low byte first
              ld = 1'b1;
              lb = txc.crc[7:0];
              s_nxt.ph = P_CRCH;
            end
            P_CRCH: begin
              ld = 1'b1;
              lb = txc.crc[15:8];
              s_nxt.ph = P_DONE;
              s_nxt.txlast = 1'b1;
            end
            P_DONE: begin
              s_nxt.st = ST_IDLE;
            end
          endcase
          if (ld) begin
            s_nxt.txv = 1'b1;
            s_nxt.txd = lb;
            s_nxt.idx = s_r.idx + 8'h01;
          end
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign tx_data_o = s_r.txd;
  assign tx_valid_o = s_r.txv;
  assign tx_last_o = s_r.txlast;
  assign reg_rd_o = (s_r.st == ST_RDREQ);
  assign reg_rd_addr_o = s_r.raddr;
  assign reg_wr_o = s_r.wr;
  assign reg_wr_addr_o = w1;
  assign reg_wr_data_o = w2;
  assign busy_o = (s_r.st != ST_IDLE);
endmodule : serial_holding_register_responder

// file: verification/shrr_chk.sv
// assertion checker for the responder ports
`timescale 1ns/100ps
module shrr_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // watched ports
  input wire logic rx_end_i,
  input wire logic tx_ready_i,
  input wire responder_pkg::byte_t tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_last_o,
  input wire logic reg_rd_o,
  input wire logic reg_wr_o,
  input wire logic busy_o
);
  import responder_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o)) else $error("tx byte changed");
  a_last_valid: assert property (tx_last_o |-> tx_valid_o)
    else $error("last flag alone");
  a_no_early: assert property (!busy_o |-> !tx_valid_o)
    else $error("tx while idle");
  a_busy_start: assert property (rx_end_i && !busy_o |=> busy_o)
    else $error("busy missing");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(rx_end_i))
    else $error("busy without end");
  a_first_gap: assert property ($rose(busy_o) |-> (!tx_valid_o) [*2])
    else $error("reply too early");
  a_wr_pulse: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write strobe long");
  // a broadcast write strobes after the responder has already gone idle
  a_wr_busy: assert property (reg_wr_o |-> $past(busy_o) && !tx_valid_o)
    else $error("write out of place");
  a_rd_pulse: assert property (reg_rd_o |=> !reg_rd_o && busy_o)
    else $error("read strobe long");
endmodule : shrr_chk
bind serial_holding_register_responder shrr_chk u_chk (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .rx_end_i(rx_end_i),
  .tx_ready_i(tx_ready_i),
  .tx_data_o(tx_data_o),
  .tx_valid_o(tx_valid_o),
  .tx_last_o(tx_last_o),
  .reg_rd_o(reg_rd_o),
  .reg_wr_o(reg_wr_o),
  .busy_o(busy_o)
);

// file: verification/query_master.sv
// remote master model: sends queries, sinks replies with stalls
`timescale 1ns/100ps
module query_master (
  // clock
  input wire logic clk_i,
  // query bytes toward the responder
  output responder_pkg::byte_t rx_data_o,
  output logic rx_valid_o,
  output logic rx_end_o,
  // reply sink
  output logic tx_ready_o
);
  import responder_pkg::*;
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // sink stalls about one cycle in four
  always @(negedge clk_i) begin
    tx_ready_o = ($urandom % 4) != 0;
  end
  // check value over a byte queue
  function automatic logic [15:0] crc16(input byte_t f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  task automatic send(input byte_t f[$], input logic spoil);
    logic [15:0] c;
    c = crc16(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8] ^ {7'h00, spoil});
    foreach (f[i]) begin
      @(negedge clk_i);
      rx_data_o = f[i];
      rx_valid_o = 1'b1;
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~rx_data_o;
    rx_end_o = 1'b1;
    @(negedge clk_i);
    rx_end_o = 1'b0;
  endtask : send
endmodule : query_master

// file: verification/serial_holding_register_responder_tb_top.sv
// self-checking bench for the holding register responder
`timescale 1ns/100ps
module serial_holding_register_responder_tb_top;
  import responder_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i;
  byte_t station_i, rx_data_i, tx_data_o;
  logic rx_valid_i, rx_end_i, tx_ready_i, tx_valid_o, tx_last_o, reg_rd_o, reg_wr_o, busy_o;
  logic [15:0] reg_rd_addr_o, rd_data, reg_wr_addr_o, reg_wr_data_o;
  int n_errors = 0;
  int n_compared = 0;
  logic [8:0] exp_q[$];
  logic [31:0] wr_q[$];
  byte_t none[$];
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  serial_holding_register_responder dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .station_i(station_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .rx_end_i(rx_end_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .reg_rd_o(reg_rd_o),
    .reg_rd_addr_o(reg_rd_addr_o), .reg_rd_data_i(rd_data), .reg_wr_o(reg_wr_o),
    .reg_wr_addr_o(reg_wr_addr_o), .reg_wr_data_o(reg_wr_data_o), .busy_o(busy_o));
  query_master m (.clk_i(clk_i), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
    .rx_end_o(rx_end_i), .tx_ready_o(tx_ready_i));
  // register contents seen by the read port
  function automatic logic [15:0] rd_val(input logic [15:0] a);
    return {a[7:0], a[15:8]} ^ 16'h5A3C;
  endfunction : rd_val
  always @(posedge clk_i) begin
    if (reg_rd_o) rd_data <= rd_val(reg_rd_addr_o);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task results;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // reply and write monitor, oldest note first
  always @(posedge clk_i) begin
    if (reset_n_i && tx_valid_o && tx_ready_i) begin
      if (exp_q.size() == 0) check("stray byte", 32'h1, 32'h0);
      else check("reply byte", {tx_last_o, tx_data_o}, exp_q.pop_front());
    end
    if (reset_n_i && reg_wr_o) begin
      if (wr_q.size() == 0) check("stray write", 32'h1, 32'h0);
      else check("write", {reg_wr_addr_o, reg_wr_data_o}, wr_q.pop_front());
    end
  end
  // send one query, note its reply, wait until the responder is idle
  task automatic run(input byte_t f[$], input byte_t r[$], input logic spoil);
    logic [15:0] c;
    c = m.crc16(r);
    if (r.size() != 0) begin
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
    end
    foreach (r[i]) exp_q.push_back({i == r.size() - 1, r[i]});
    m.send(f, spoil);
    repeat (3) @(negedge clk_i);
    for (int k = 0; k < 3000 && busy_o !== 1'b0; k++) @(negedge clk_i);
    // a responder still busy here means the wait limit ran out
    check("idle", busy_o, 32'h0);
    check("reply left", exp_q.size(), 32'h0);
    check("write left", wr_q.size(), 32'h0);
  endtask : run
  initial begin
    #400000;
    n_errors++;
    results();
  end
  initial begin
    byte_t f[$];
    byte_t r[$];
    byte_t cnt[5];
    logic [15:0] a, d, v;
    void'($urandom(32'hAAC29E25));
    reset_n_i = 1'b0;
    station_i = 8'(1 + $urandom % 247);
    cnt = '{8'h01, 8'h03, 8'h7D, 8'h00, 8'h7E};
    repeat (8) @(negedge clk_i);
    reset_n_i = 1'b1;
    check("crc", m.crc16('{8'h11, 8'h03, 8'h03, 8'hEB, 8'h00, 8'h03}), 16'h2B77);
    foreach (cnt[j]) begin
      a = 16'($urandom % 32'hFF00);
      f = '{station_i, 8'h03, a[15:8], a[7:0], 8'h00, cnt[j]};
      r = '{station_i, 8'h03, 8'(2 * cnt[j])};
      for (int i = 0; i < cnt[j]; i++) begin
        v = rd_val(a + 16'(i));
        r.push_back(v[15:8]);
        r.push_back(v[7:0]);
      end
      if (cnt[j] == 8'h00 || cnt[j] > 8'h7D) r = '{station_i, 8'h83, 8'h03};
      run(f, r, 1'b0);
    end
    f = '{8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h02};
    run(f, none, 1'b0);
    // echo, broadcast, then spoilt check value
    for (int w = 0; w < 3; w++) begin
      a = 16'($urandom);
      d = 16'($urandom);
      f = '{(w == 1) ? 8'h00 : station_i, 8'h06, a[15:8], a[7:0], d[15:8], d[7:0]};
      if (w != 2) wr_q.push_back({a, d});
      r = f;
      if (w != 0) r = none;
      run(f, r, w == 2);
    end
    d = 16'($urandom);
    f = '{station_i, 8'h08, 8'h00, 8'h00, d[15:8], d[7:0]};
    run(f, f, 1'b0);
    f[0] = 8'h00;
    run(f, none, 1'b0);
    f = '{station_i, 8'h08, 8'h00, 8'h01, d[15:8], d[7:0]};
    r = '{station_i, 8'h88, 8'h01};
    run(f, r, 1'b0);
    f[1] = 8'h05;
    r = '{station_i, 8'h85, 8'h01};
    run(f, r, 1'b0);
    f[0] = station_i + 8'h01;
    run(f, none, 1'b0);
    results();
  end
endmodule : serial_holding_register_responder_tb_top
